// ### rtl/phase_offset_pkg.sv
/*
 * Shared constants for the oscillator phase offset register bank
 * (sixth, seventh and eighth logical channels).
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package phase_offset_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int PHASE_W = 16;
    localparam int NUM_CH = 3;
    localparam int NUM_REG = 6;
    localparam int SEQ_W = 3;
    // printed offsets are not multiples of four: they are indexes
    localparam logic [ADDR_W-1:0] IDX_CH5_LOW = 12'h090;
    localparam logic [ADDR_W-1:0] IDX_CH5_HIGH = 12'h091;
    localparam logic [ADDR_W-1:0] IDX_CH6_LOW = 12'h092;
    localparam logic [ADDR_W-1:0] IDX_CH6_HIGH = 12'h093;
    localparam logic [ADDR_W-1:0] IDX_CH7_LOW = 12'h094;
    localparam logic [ADDR_W-1:0] IDX_CH7_HIGH = 12'h095;
    localparam logic [ADDR_W-1:0] IDX_MODE = 12'h098;
    localparam logic [ADDR_W-1:0] IDX_SEQ = 12'h099;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h09A;
    localparam logic [BYTE_W-1:0] PHASE_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] MODE_CW_BIT = 2'h1;
    localparam logic [1:0] MODE_DDC_BIT = 2'h2;
    localparam logic [3*SEQ_W-1:0] SEQ_RESET = 9'h0FA;
    localparam logic [PHASE_W-1:0] PHASE_ZERO = 16'h0000;
    // all ones is 359.995 degrees, 0x00FF about 1.4 degrees
    localparam real PHASE_FULL_DEG = 360.0;
endpackage

// ### rtl/phase_byte_store.sv
/*
 * Small memory of byte registers holding the phase offset bytes.
 * Assumes a single write port and registered read data.
 */
`timescale 1ns/1ps
`default_nettype none
module phase_byte_store #(
    parameter int DEPTH = 6,
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data_ff,
    // all bytes, flat
    output logic [DEPTH*WIDTH-1:0] all_ff
);
    logic [DEPTH*WIDTH-1:0] nxt_all;
    logic [WIDTH-1:0] nxt_rd_data;

    always_comb
    begin
        nxt_all = all_ff;
        if (wr_en)
        begin
            nxt_all[wr_idx*WIDTH +: WIDTH] = wr_data;
        end
        nxt_rd_data = all_ff[rd_idx*WIDTH +: WIDTH];
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            all_ff <= '0;
            rd_data_ff <= '0;
        end
        else
        begin
            all_ff <= nxt_all;
            rd_data_ff <= nxt_rd_data;
        end
    end
endmodule // phase_byte_store
`default_nettype wire

// ### rtl/phase_offset_regs.sv
/*
 * APB register bank for the oscillator phase offsets of logical channels
 * five to seven, plus mode enable and channel sequence slots.
 * Assumes an APB master on clk_sys; the mode and sequence inputs of the
 * datapath are local registers since the wider channel map lives elsewhere.
 */
// Added by the designer: the APB register port.
// Function
// - sixth channel phase word: low byte at 0x90, high byte at 0x91
// - seventh channel phase word: low byte at 0x92, high at 0x93
// - eighth channel phase word: low byte at 0x94, high at 0x95
// - phase word is unsigned fraction of a turn, 0xFFFF near 360 degrees
// - low byte carries the fine weight, 0x00FF about 1.4 degrees
// - first pair applies to input in sixth sequence slot
// - second pair applies to input in seventh sequence slot
// - third pair applies to input in eighth sequence slot
// - offsets used only in continuous wave or down-conversion mode
`timescale 1ns/1ps
`default_nettype none
module phase_offset_regs
    import phase_offset_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [phase_offset_pkg::ADDR_W-1:0] paddr,
    input wire logic [phase_offset_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [phase_offset_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // phase words for the three channels, gated by mode
    output logic [phase_offset_pkg::PHASE_W-1:0] sixth_channel_phase_word,
    output logic [phase_offset_pkg::PHASE_W-1:0] seventh_channel_phase_word,
    output logic [phase_offset_pkg::PHASE_W-1:0] eighth_channel_phase_word,
    // physical input that each word steers
    output logic [phase_offset_pkg::SEQ_W-1:0] sixth_channel_input,
    output logic [phase_offset_pkg::SEQ_W-1:0] seventh_channel_input,
    output logic [phase_offset_pkg::SEQ_W-1:0] eighth_channel_input,
    // offsets currently in force
    output logic phase_active
);
    import phase_offset_pkg::*;

    logic [2:0] store_idx;
    logic store_hit;
    logic store_wr;
    logic [BYTE_W-1:0] store_rd;
    logic [NUM_REG*BYTE_W-1:0] store_all;
    logic [1:0] mode_ff, nxt_mode;
    logic [3*SEQ_W-1:0] seq_ff, nxt_seq;
    logic [DATA_W-1:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic rd_store_ff, nxt_rd_store;
    logic [PHASE_W-1:0] w6_ff, w7_ff, w8_ff, nxt_w6, nxt_w7, nxt_w8;
    logic [3*SEQ_W-1:0] sel_ff, nxt_sel;
    logic act_ff, nxt_act;
    logic setup;
    logic known;

    function automatic logic [2:0] reg_slot(input logic [ADDR_W-1:0] idx);
        return 3'(idx - IDX_CH5_LOW);
    endfunction

    function automatic logic [PHASE_W-1:0] word_of(input logic [NUM_REG*BYTE_W-1:0] b,
                                                    input int ch);
        return {b[(2*ch+1)*BYTE_W +: BYTE_W], b[2*ch*BYTE_W +: BYTE_W]};
    endfunction

    // index is byte address over four
    logic [ADDR_W-1:0] idx;
    assign idx = {2'b00, paddr[ADDR_W-1:2]};
    assign setup = psel && !penable;
    assign store_hit = (idx >= IDX_CH5_LOW) && (idx <= IDX_CH7_HIGH);
    assign store_idx = store_hit ? reg_slot(idx) : 3'h0;
    assign known = store_hit || (idx == IDX_MODE) || (idx == IDX_SEQ)
                   || (idx == IDX_STATUS);
    // write takes effect in the setup cycle's following access edge
    assign store_wr = psel && penable && pready_ff && pwrite && store_hit
                      && pstrb[0];

    phase_byte_store #(
        .DEPTH(NUM_REG),
        .WIDTH(BYTE_W)
    ) u_store (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wr_en(store_wr),
        .wr_idx(store_idx),
        .wr_data(pwdata[BYTE_W-1:0]),
        .rd_idx(store_idx),
        .rd_data_ff(store_rd),
        .all_ff(store_all)
    );

    // bus: no wait states, read data registered in the setup cycle
    always_comb
    begin
        nxt_pready = setup;
        nxt_pslverr = setup && !known;
        nxt_rd_store = setup && store_hit;
        nxt_prdata = '0;
        nxt_mode = mode_ff;
        nxt_seq = seq_ff;
        if (setup && !pwrite)
        begin
            // byte registers read from the flat copy so prdata leaves a flop
            if (store_hit)
            begin
                nxt_prdata = {24'h0, store_all[store_idx*BYTE_W +: BYTE_W]};
            end
            else if (idx == IDX_MODE)
            begin
                nxt_prdata = {30'h0, mode_ff};
            end
            else if (idx == IDX_SEQ)
            begin
                nxt_prdata = {23'h0, seq_ff};
            end
            else if (idx == IDX_STATUS)
            begin
                nxt_prdata = {31'h0, act_ff};
            end
        end
        if (psel && penable && pready_ff && pwrite)
        begin
            if (idx == IDX_MODE && pstrb[0])
            begin
                nxt_mode = pwdata[1:0];
            end
            if (idx == IDX_SEQ)
            begin
                if (pstrb[0])
                begin
                    nxt_seq[7:0] = pwdata[7:0];
                end
                if (pstrb[1])
                begin
                    nxt_seq[8] = pwdata[8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            rd_store_ff <= 1'b0;
            prdata_ff <= '0;
            mode_ff <= MODE_RESET;
            seq_ff <= SEQ_RESET;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            rd_store_ff <= nxt_rd_store;
            prdata_ff <= nxt_prdata;
            mode_ff <= nxt_mode;
            seq_ff <= nxt_seq;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    // the store's own read port only cross-checks this path, see AST_STORE_PORT
    assign prdata = prdata_ff;

    // datapath: words to the slot-selected inputs, only in an active mode
    always_comb
    begin
        nxt_act = |(mode_ff & (MODE_CW_BIT | MODE_DDC_BIT));
        nxt_w6 = nxt_act ? word_of(store_all, 0) : PHASE_ZERO;
        nxt_w7 = nxt_act ? word_of(store_all, 1) : PHASE_ZERO;
        nxt_w8 = nxt_act ? word_of(store_all, 2) : PHASE_ZERO;
        nxt_sel = seq_ff;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            act_ff <= 1'b0;
            w6_ff <= PHASE_ZERO;
            w7_ff <= PHASE_ZERO;
            w8_ff <= PHASE_ZERO;
            sel_ff <= SEQ_RESET;
        end
        else
        begin
            act_ff <= nxt_act;
            w6_ff <= nxt_w6;
            w7_ff <= nxt_w7;
            w8_ff <= nxt_w8;
            sel_ff <= nxt_sel;
        end
    end

    assign sixth_channel_phase_word = w6_ff;
    assign seventh_channel_phase_word = w7_ff;
    assign eighth_channel_phase_word = w8_ff;
    assign sixth_channel_input = sel_ff[0 +: SEQ_W];
    assign seventh_channel_input = sel_ff[SEQ_W +: SEQ_W];
    assign eighth_channel_input = sel_ff[2*SEQ_W +: SEQ_W];
    assign phase_active = act_ff;

    // bus protocol and register access checks
    sequence s_wr_low6;
        store_wr && idx == IDX_CH5_LOW;
    endsequence

    sequence s_access_wr;
        psel && penable && pready && pwrite;
    endsequence

    sequence s_setup_rd;
        setup && !pwrite;
    endsequence

    AST_ONE_WAIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
        setup |=> pready ##1 !pready)
        else $error("pready not exactly one cycle after setup");
    AST_ERR_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!arst_n)
        setup && !known |=> pready && pslverr)
        else $error("unmapped access not flagged");
    AST_NO_ERR_MAPPED: assert property (@(posedge clk_sys) disable iff (!arst_n)
        setup && known |=> !pslverr)
        else $error("mapped access flagged as error");
    AST_READBACK: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_setup_rd ##0 (store_hit) ##1 pready
        |-> prdata == {24'h0, store_all[$past(store_idx)*BYTE_W +: BYTE_W]})
        else $error("phase register readback mismatch");
    AST_STORE_PORT: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_store_ff && !pwrite |-> prdata == {24'h0, store_rd})
        else $error("read data differs from store read port");
    AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_setup_rd ##0 (!known) |=> prdata == '0)
        else $error("unmapped read returned nonzero data");
    AST_NO_LANE_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_access_wr ##0 (store_hit && !pstrb[0]) |=> $stable(store_all))
        else $error("phase byte changed without lane strobe");
    AST_MODE_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_access_wr ##0 (idx == IDX_MODE && pstrb[0]) |=> mode_ff == $past(pwdata[1:0]))
        else $error("mode register did not take the write");
    AST_STATUS_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_setup_rd ##0 (idx == IDX_STATUS) |=> prdata == {31'h0, $past(act_ff)})
        else $error("status readback does not show active flag");
    AST_SEQ_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_access_wr ##0 (idx == IDX_SEQ && pstrb[0]) |=> seq_ff[7:0] == $past(pwdata[7:0]))
        else $error("sequence register low lane did not take the write");

    // datapath checks: a stored byte reaches its word two edges later
    AST_LOW_BYTE_FINE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_wr_low6 ##1 (mode_ff != 2'h0) [*2]
        |-> sixth_channel_phase_word[7:0] == $past(pwdata[7:0], 3))
        else $error("low byte of sixth channel word not from 0x90");
    AST_HIGH6: assert property (@(posedge clk_sys) disable iff (!arst_n)
        store_wr && idx == IDX_CH5_HIGH ##1 act_ff [*2]
        |-> sixth_channel_phase_word[15:8] == $past(pwdata[7:0], 3))
        else $error("high byte of sixth channel word wrong");
    AST_LOW7: assert property (@(posedge clk_sys) disable iff (!arst_n)
        store_wr && idx == IDX_CH6_LOW ##1 act_ff [*2]
        |-> seventh_channel_phase_word[7:0] == $past(pwdata[7:0], 3))
        else $error("low byte of seventh channel word wrong");
    AST_HIGH7: assert property (@(posedge clk_sys) disable iff (!arst_n)
        store_wr && idx == IDX_CH6_HIGH ##1 act_ff [*2]
        |-> seventh_channel_phase_word[15:8] == $past(pwdata[7:0], 3))
        else $error("high byte of seventh channel word wrong");
    AST_LOW8: assert property (@(posedge clk_sys) disable iff (!arst_n)
        store_wr && idx == IDX_CH7_LOW ##1 act_ff [*2]
        |-> eighth_channel_phase_word[7:0] == $past(pwdata[7:0], 3))
        else $error("low byte of eighth channel word wrong");
    AST_HIGH8: assert property (@(posedge clk_sys) disable iff (!arst_n)
        store_wr && idx == IDX_CH7_HIGH ##1 act_ff [*2]
        |-> eighth_channel_phase_word[15:8] == $past(pwdata[7:0], 3))
        else $error("high byte of eighth channel word wrong");
    AST_WORD_ORDER: assert property (@(posedge clk_sys) disable iff (!arst_n)
        phase_active && $stable(store_all)
        |-> sixth_channel_phase_word == {store_all[BYTE_W +: BYTE_W], store_all[0 +: BYTE_W]})
        else $error("sixth channel word bytes out of order");
    AST_INACTIVE_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !phase_active |-> sixth_channel_phase_word == PHASE_ZERO
        && seventh_channel_phase_word == PHASE_ZERO && eighth_channel_phase_word == PHASE_ZERO)
        else $error("phase word nonzero outside active mode");
    AST_ACTIVE_MODE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ##1 phase_active == ($past(mode_ff) != 2'h0))
        else $error("active flag does not follow mode");
    AST_SLOT6: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sixth_channel_input == $past(seq_ff[2:0]))
        else $error("sixth slot input wrong");
    AST_SLOT7: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seventh_channel_input == $past(seq_ff[5:3]))
        else $error("seventh slot input wrong");
    AST_SLOT8: assert property (@(posedge clk_sys) disable iff (!arst_n)
        eighth_channel_input == $past(seq_ff[8:6]))
        else $error("eighth slot input wrong");
endmodule // phase_offset_regs
`default_nettype wire

// ### tb/test_phase_offset_regs.sv
/*
 * Self-checking bench for the phase offset register bank.
 * Assumes the register bank answers APB with one access cycle and
 * drives its phase outputs one cycle after each store.
 */
`timescale 1ns/1ps
`default_nettype none
module test_phase_offset_regs;
    import phase_offset_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic phase_active;
    wire [2:0][PHASE_W-1:0] word_o;
    wire [2:0][SEQ_W-1:0] in_o;
    int ph [6];
    int mode = 0;
    int seq = SEQ_RESET;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int r;

    always #5 clk_sys = ~clk_sys;

    phase_offset_regs u_phase_offset_regs (
        .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sixth_channel_phase_word(word_o[0]), .seventh_channel_phase_word(word_o[1]),
        .eighth_channel_phase_word(word_o[2]), .sixth_channel_input(in_o[0]),
        .seventh_channel_input(in_o[1]), .eighth_channel_input(in_o[2]),
        .phase_active(phase_active)
    );

    task automatic results();
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_out(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // request held until the rising edge where pready is seen high; only the watchdog ends a wait
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic bit mapped(input logic [9:0] idx);
        return (idx >= 10'h090 && idx <= 10'h095) || (idx >= 10'h098 && idx <= 10'h09A);
    endfunction

    function automatic logic [31:0] exp_rd(input logic [9:0] idx);
        if (idx >= 10'h090 && idx <= 10'h095)
            return ph[idx - 10'h090];
        if (idx == 10'h098)
            return mode;
        if (idx == 10'h099)
            return seq;
        if (idx == 10'h09A)
            return 32'(mode != 0);
        return 32'h0;
    endfunction

    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, d, st, rd, err);
        chk_rd({31'h0, err}, {31'h0, !mapped(idx)});
        if (idx >= 10'h090 && idx <= 10'h095 && st[0])
            ph[idx - 10'h090] = d[7:0];
        if (idx == 10'h098 && st[0])
            mode = d[1:0];
        if (idx == 10'h099)
            seq = {st[1] ? d[8] : seq[8], st[0] ? d[7:0] : seq[7:0]};
    endtask

    task automatic rd_chk(input logic [9:0] idx);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0, 4'h0, rd, err);
        chk_rd(rd, exp_rd(idx));
        chk_rd({31'h0, err}, {31'h0, !mapped(idx)});
    endtask

    // outputs settle one cycle after the store; allow two
    task automatic check_outs();
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        for (int c = 0; c < 3; c++)
        begin
            chk_out(word_o[c], (mode != 0) ? 16'((ph[2*c+1] << 8) | ph[2*c]) : 16'h0);
            chk_out(16'(in_o[c]), 16'((seq >> (3*c)) & 7));
        end
        chk_out({15'h0, phase_active}, {15'h0, mode != 0});
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        r = $urandom(32'h3483);
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        check_outs();
        for (int i = 0; i < 6; i++)
            rd_chk(10'h090 + 10'(i));
        for (int i = 0; i < 6; i++)
            wr(10'h090 + 10'(i), $urandom, 4'hF);
        for (int i = 0; i < 6; i++)
            rd_chk(10'h090 + 10'(i));
        // every mode combination, with status readback
        for (int m = 0; m < 4; m++)
        begin
            wr(IDX_MODE[9:0], 32'(m), 4'hF);
            check_outs();
            rd_chk(IDX_STATUS[9:0]);
        end
        // boundary words: fine byte only, and full scale
        wr(IDX_CH5_LOW[9:0], 32'hFF, 4'hF);
        wr(IDX_CH5_HIGH[9:0], 32'h00, 4'hF);
        wr(IDX_CH7_LOW[9:0], 32'hFF, 4'hF);
        wr(IDX_CH7_HIGH[9:0], 32'hFF, 4'hF);
        check_outs();
        // one byte at a time: the word follows each byte
        wr(IDX_CH6_LOW[9:0], $urandom, 4'hF);
        check_outs();
        wr(IDX_CH6_HIGH[9:0], $urandom, 4'hF);
        check_outs();
        // sequence slots: full word, then low lane only
        wr(IDX_SEQ[9:0], $urandom, 4'hF);
        check_outs();
        rd_chk(IDX_SEQ[9:0]);
        wr(IDX_SEQ[9:0], $urandom, 4'h1);
        check_outs();
        rd_chk(IDX_SEQ[9:0]);
        // refused accesses leave the state untouched
        wr(IDX_CH5_HIGH[9:0], 32'h5A, 4'h0);
        wr(10'h09B, 32'hA5, 4'hF);
        rd_chk(IDX_CH5_HIGH[9:0]);
        rd_chk(10'h09B);
        check_outs();
        // reset in mid-run returns every register to its reset value
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (ph[i])
            ph[i] = PHASE_RESET;
        mode = MODE_RESET;
        seq = SEQ_RESET;
        check_outs();
        for (int i = 0; i < 6; i++)
            rd_chk(10'h090 + 10'(i));
        rd_chk(IDX_SEQ[9:0]);
        results();
    end
endmodule // test_phase_offset_regs
`default_nettype wire
